// >>> src/dual_level_intc.v
// Purpose: Two-level interrupt controller with per-source enables.
// Assumes: Peripheral requests are on CLOCK; the GPIO line is an outside pin.
// Notes: Registered request outputs lag the status registers by one cycle.
`timescale 1ns/10ps
`default_nettype none
`include "intc_consts.vh"

module dual_level_intc (
  input wire CLOCK,
  input wire RST_N,
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [7:0] WB_ADR_I,
  input wire [3:0] WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  output reg [31:0] WB_DAT_O,
  output reg WB_ACK_O,
  input wire [9:0] PERIPH_REQ,
  input wire GPIO_LINE,
  input wire POWER_DOWN,
  output reg NORMAL_REQ,
  output reg FAST_REQ,
  output reg PERIPH_WAKE,
  output reg INT_OUT
);

  // ************************************************************
  // Helpers
  // ************************************************************
  function [31:0] lanes;
    input [3:0] sel;
    begin
      lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    end
  endfunction

  // ************************************************************
  // Pin synchroniser
  // ************************************************************
  reg gpio_meta_q;
  reg gpio_sync_q;
  always @(posedge CLOCK) begin
    if (!RST_N) begin
      gpio_meta_q <= 1'b0;
      gpio_sync_q <= 1'b0;
    end else begin
      gpio_meta_q <= GPIO_LINE;
      gpio_sync_q <= gpio_meta_q;
    end
  end

  // ************************************************************
  // Bus decode
  // ************************************************************
  reg [31:0] en_normal_q;
  reg [31:0] en_fast_q;
  reg [31:0] prog_q;
  reg [31:0] evt_q;
  reg [31:0] evt_mask_q;
  reg fast_prev_q;
  reg normal_prev_q;
  reg wake_prev_q;

  wire req = WB_CYC_I & WB_STB_I;
  // Writes land on the edge where ack is seen high, as the master expects.
  wire wr = req & WB_WE_I & WB_ACK_O;
  wire [31:0] wmask = WB_DAT_I & lanes(WB_SEL_I);
  wire wr_nset = wr & (WB_ADR_I == `OFF_NORMAL_SET);
  wire wr_nclr = wr & (WB_ADR_I == `OFF_NORMAL_CLR);
  wire wr_fset = wr & (WB_ADR_I == `OFF_FAST_SET);
  wire wr_fclr = wr & (WB_ADR_I == `OFF_FAST_CLR);
  wire wr_prog = wr & (WB_ADR_I == `OFF_PROG_CFG);
  wire wr_evts = wr & (WB_ADR_I == `OFF_EVT_STATUS);
  wire wr_evtm = wr & (WB_ADR_I == `OFF_EVT_MASK);

  // ************************************************************
  // Source map and status
  // ************************************************************
  wire [31:0] src_bits;
  assign src_bits[`PERIPH_HI:`PERIPH_LO] = PERIPH_REQ; // [R1] [R2] [R6]
  assign src_bits[`BIT_GPIO] = gpio_sync_q; // [R1]
  assign src_bits[12] = 1'b0; // [R18]
  assign src_bits[31:14] = 18'h0; // [R18]
  assign src_bits[1:0] = 2'b00;

  wire [31:0] fast_sta_hi;
  wire fast_or;
  wire [31:0] raw_normal;
  wire [31:0] raw_fast;
  wire [31:0] sta_normal;
  wire [31:0] sta_fast;

  // The programmed source bypasses the enables, so it cannot be masked.
  assign fast_sta_hi = (src_bits & en_fast_q) |
                       ({31'h0, prog_q[`PROG_FAST_BIT]} << `BIT_PROG); // [R11] [R13]
  assign fast_or = |fast_sta_hi[31:1]; // [R3]
  assign raw_fast = src_bits |
                    ({31'h0, prog_q[`PROG_FAST_BIT]} << `BIT_PROG) |
                    {31'h0, fast_or}; // [R3] [R11] [R13]
  assign raw_normal = src_bits |
                      ({31'h0, prog_q[`PROG_NORMAL_BIT]} << `BIT_PROG) |
                      {31'h0, fast_or}; // [R3] [R13]
  assign sta_fast = fast_sta_hi | {31'h0, fast_or}; // [R3] [R9]
  assign sta_normal = (src_bits & en_normal_q) |
                      ({31'h0, prog_q[`PROG_NORMAL_BIT]} << `BIT_PROG) |
                      {31'h0, fast_or}; // [R3] [R9] [R13]

  wire normal_any = |sta_normal; // [R5]
  // Only sources the software enabled may wake; bit 0 and bit 1 are excluded.
  wire wake_any = POWER_DOWN & (|(src_bits & (en_normal_q | en_fast_q))); // [R14]

  // ************************************************************
  // Enable masks and programmed interrupts
  // ************************************************************
  wire [31:0] nset = wr_nset ? (wmask & `ENABLE_MASK) : 32'h0000_0000; // [R4] [R7]
  wire [31:0] fset = wr_fset ? (wmask & `ENABLE_MASK) : 32'h0000_0000; // [R4] [R7]
  wire [31:0] nclr = wr_nclr ? (wmask & `ENABLE_MASK) : 32'h0000_0000; // [R4] [R8]
  wire [31:0] fclr = wr_fclr ? (wmask & `ENABLE_MASK) : 32'h0000_0000; // [R4] [R8]

  always @(posedge CLOCK) begin
    if (!RST_N) begin
      en_normal_q <= `ENABLE_RESET; // [R17]
      en_fast_q <= `ENABLE_RESET; // [R17]
      prog_q <= `PROG_RESET; // [R17]
    end else begin
      // Setting one level removes the source from the other level.
      en_normal_q <= (en_normal_q & ~nclr & ~fset) | nset; // [R7] [R8] [R12]
      en_fast_q <= (en_fast_q & ~fclr & ~nset) | fset; // [R7] [R8] [R12]
      if (wr_prog) begin
        prog_q <= (prog_q & ~lanes(WB_SEL_I)) |
                  (WB_DAT_I & lanes(WB_SEL_I) & `PROG_CFG_MASK); // [R13] [R18]
      end
    end
  end

  // ************************************************************
  // Event status, mask and interrupt output
  // ************************************************************
  wire [31:0] evt_set = {29'h0, wake_any & ~wake_prev_q,
                         fast_or & ~fast_prev_q, normal_any & ~normal_prev_q};
  wire [31:0] evt_clr = wr_evts ? wmask : 32'h0000_0000;

  always @(posedge CLOCK) begin
    if (!RST_N) begin
      evt_q <= `EVT_RESET;
      evt_mask_q <= `EVT_RESET;
      fast_prev_q <= 1'b0;
      normal_prev_q <= 1'b0;
      wake_prev_q <= 1'b0;
      NORMAL_REQ <= 1'b0;
      FAST_REQ <= 1'b0;
      PERIPH_WAKE <= 1'b0;
      INT_OUT <= 1'b0;
    end else begin
      // A new event in the clearing cycle survives the clear.
      evt_q <= ((evt_q & ~evt_clr) | evt_set) & `EVT_MASK_BITS;
      if (wr_evtm) begin
        evt_mask_q <= (evt_mask_q & ~lanes(WB_SEL_I)) |
                      (WB_DAT_I & lanes(WB_SEL_I) & `EVT_MASK_BITS);
      end
      fast_prev_q <= fast_or;
      normal_prev_q <= normal_any;
      wake_prev_q <= wake_any;
      NORMAL_REQ <= normal_any; // [R5]
      FAST_REQ <= fast_or; // [R3]
      PERIPH_WAKE <= wake_any; // [R14]
      INT_OUT <= |(evt_q & evt_mask_q);
    end
  end

  // ************************************************************
  // Wishbone answer
  // ************************************************************
  reg [31:0] rdata;
  always @* begin
    case (WB_ADR_I)
      `OFF_NORMAL_RAW: rdata = raw_normal; // [R6]
      `OFF_NORMAL_SET: rdata = en_normal_q;
      `OFF_NORMAL_STA: rdata = sta_normal; // [R10]
      `OFF_FAST_RAW: rdata = raw_fast; // [R11]
      `OFF_FAST_SET: rdata = en_fast_q;
      `OFF_FAST_STA: rdata = sta_fast; // [R10]
      `OFF_PROG_CFG: rdata = prog_q;
      `OFF_EVT_STATUS: rdata = evt_q;
      `OFF_EVT_MASK: rdata = evt_mask_q;
      default: rdata = 32'h0000_0000; // [R18]
    endcase
  end

  always @(posedge CLOCK) begin
    if (!RST_N) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= req & ~WB_ACK_O;
      if (req & ~WB_ACK_O & ~WB_WE_I) begin
        WB_DAT_O <= rdata;
      end else begin
        WB_DAT_O <= 32'h0000_0000;
      end
    end
  end

endmodule
`default_nettype wire

// >>> src/intc_consts.vh
// Purpose: Shared constants for the two-level interrupt controller.
// Assumes: Byte addresses on a 32-bit classic Wishbone slave port.
// Notes: Every register takes one aligned word.
//
// Functional notes
// [R1] Same source bit positions in all registers; 2 timer, 11 osc cal, 13 GPIO.
// [R2] Bits 3 to 10: wake timer, watchdog, LIN, NVM, PLL, converter, SPI, HV.
// [R3] Bit 0 of both signal and status is OR of fast status 31..1.
// [R4] Bit 1 is the programmed source; ignored by enable-set and mask-clear.
// [R5] Normal request line is the OR of all 32 normal status bits.
// [R6] Raw signal follows the peripheral request; writes to it do nothing.
// [R7] Writing 1 to enable-set enables a source; writing 0 changes nothing.
// [R8] Each 1 written to mask-clear clears that enable bit only.
// [R9] Active status equals raw signal AND enable per bit.
// [R10] No priority encoder or vector; software reads status to order sources.
// [R11] Fast level has the same four registers behaving like the normal ones.
// [R12] Setting an enable in one level clears the same enable in the other.
// [R13] Programmed config bit 2 drives fast bit 1, bit 1 drives normal bit 1.
// [R14] Enabled interrupt during power-down wakes peripherals; core stays down.
// [R15] Peripherals hold a request at least the minimum latency time.
// [R16] Handler should capture its level's status register at entry.
// [R17] Enable and programmed bits reset to zero.
// [R18] Reserved bits read zero and ignore writes.
`ifndef INTC_CONSTS_VH
`define INTC_CONSTS_VH

`define OFF_NORMAL_RAW 8'h00
`define OFF_NORMAL_SET 8'h04
`define OFF_NORMAL_CLR 8'h08
`define OFF_NORMAL_STA 8'h0C
`define OFF_FAST_RAW 8'h10
`define OFF_FAST_SET 8'h14
`define OFF_FAST_CLR 8'h18
`define OFF_FAST_STA 8'h1C
`define OFF_PROG_CFG 8'h20
`define OFF_EVT_STATUS 8'h24
`define OFF_EVT_MASK 8'h28

`define BIT_FAST_OR 0
`define BIT_PROG 1
`define BIT_TIMER 2
`define BIT_OSC_CAL 11
`define BIT_GPIO 13
`define PERIPH_LO 2
`define PERIPH_HI 11

`define PROG_NORMAL_BIT 1
`define PROG_FAST_BIT 2
`define PROG_CFG_MASK 32'h0000_0006

`define ENABLE_MASK 32'h0000_2FFC
`define ENABLE_RESET 32'h0000_0000
`define PROG_RESET 32'h0000_0000

`define EVT_NORMAL 0
`define EVT_FAST 1
`define EVT_WAKE 2
`define EVT_MASK_BITS 32'h0000_0007
`define EVT_RESET 32'h0000_0000

`endif

// >>> bench/periph_sources.sv
// Purpose: Peripheral request sources beside the controller.
// Assumes: Requests are levels on the controller clock.
// Notes: A request holds until its own clear, as a real peripheral does.
`timescale 1ns/10ps
`default_nettype none
module periph_sources (
  input wire logic clock,
  input wire logic [10:0] raise,
  input wire logic [10:0] drop,
  output logic [9:0] periph_req,
  output logic gpio_line
);
  logic [10:0] req_q = '0;
  // Requests never pulse, so none is shorter than the latency.
  always @(posedge clock) begin
    req_q <= (req_q | raise) & ~drop;
  end
  assign periph_req = req_q[9:0];
  assign gpio_line = req_q[10];
endmodule
`default_nettype wire

// >>> bench/dual_level_intc_assertions.sv
// Purpose: Port assertions for the interrupt controller.
// Assumes: One clock, synchronous reset.
// Notes: Enables are internal, so only port relations are checked.
`timescale 1ns/10ps
`default_nettype none
`include "intc_consts.vh"
module intc_checker (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic POWER_DOWN,
  input wire logic NORMAL_REQ,
  input wire logic FAST_REQ,
  input wire logic PERIPH_WAKE,
  input wire logic INT_OUT
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  ack_take_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack late");
  ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack long");
  idle_data_a: assert property (!WB_ACK_O |-> WB_DAT_O == '0) else $error("idle data");
  clr_read_a: assert property (WB_ACK_O && !$past(WB_WE_I) &&
    $past(WB_ADR_I) == `OFF_NORMAL_CLR |-> WB_DAT_O == '0) else $error("clear read");
  reserved_zero_a: assert property (WB_ACK_O |-> WB_DAT_O[31:14] == '0 && !WB_DAT_O[12])
    else $error("reserved set");
  fast_in_normal_a: assert property (FAST_REQ |-> NORMAL_REQ) else $error("fast alone");
  wake_power_a: assert property (PERIPH_WAKE |-> $past(POWER_DOWN)) else $error("wake");
  wake_drop_a: assert property (!POWER_DOWN |=> !PERIPH_WAKE) else $error("wake stays");
  reset_quiet_a: assert property ($rose(RST_N) |-> !NORMAL_REQ && !FAST_REQ && !INT_OUT)
    else $error("reset req");
endmodule
bind dual_level_intc intc_checker chk (.CLOCK(CLOCK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O),
  .WB_ACK_O(WB_ACK_O), .POWER_DOWN(POWER_DOWN), .NORMAL_REQ(NORMAL_REQ), .FAST_REQ(FAST_REQ),
  .PERIPH_WAKE(PERIPH_WAKE), .INT_OUT(INT_OUT));
`default_nettype wire

// >>> bench/dual_level_intc_test.sv
// Purpose: Self-checking bench for the interrupt controller.
// Assumes: Classic Wishbone, one access at a time.
// Notes: Expected values come from the bench's own model.
`timescale 1ns/10ps
`default_nettype none
`include "intc_consts.vh"
module dual_level_intc_test;
  logic clock = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, pd = 0, ack, gpio, nreq, freq, wake, iout;
  logic [7:0] adr = '0;
  logic [9:0] preq;
  logic [10:0] raise = '0, drop = '0;
  logic [31:0] wd = '0, rdat, q, d, e, hw = '0, nen = '0, fen = '0;
  logic [2:0] cfg = '0;
  int mismatches = 0, n_compared = 0, seed = 32'hce99;
  dual_level_intc dut (.CLOCK(clock), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wd), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .PERIPH_REQ(preq), .GPIO_LINE(gpio), .POWER_DOWN(pd), .NORMAL_REQ(nreq),
    .FAST_REQ(freq), .PERIPH_WAKE(wake), .INT_OUT(iout));
  periph_sources src (.clock(clock), .raise(raise), .drop(drop), .periph_req(preq),
    .gpio_line(gpio));
  always #12.5 clock = ~clock;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wd <= v;
    // Ack is looked at on rising edges only; the watchdog ends a wait that never ends.
    do begin
      @(posedge clock);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 0;
    stb <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    wb(0, a, '0);
    chk(q, x);
  endtask
  // Bit 0 mirrors the fast OR and bit 1 the programmed source, in both levels.
  function automatic logic [31:0] exp_reg(input logic [7:0] a);
    logic [31:0] f;
    f = (hw & fen) | {30'b0, cfg[2], 1'b0};
    f[0] = |f[31:1];
    case (a)
      `OFF_NORMAL_RAW: exp_reg = hw | {30'b0, cfg[1], f[0]};
      `OFF_NORMAL_SET: exp_reg = nen;
      `OFF_NORMAL_STA: exp_reg = (hw & nen) | {30'b0, cfg[1], f[0]};
      `OFF_FAST_RAW: exp_reg = hw | {30'b0, cfg[2], f[0]};
      `OFF_FAST_SET: exp_reg = fen;
      `OFF_FAST_STA: exp_reg = f;
      default: exp_reg = '0;
    endcase
  endfunction
  task automatic test_done();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    test_done();
  end
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1;
    for (int a = 0; a < 48; a += 4) rd(a[7:0], '0);
    $display("Reset value test done");
    wb(1, `OFF_EVT_MASK, 32'h0000_0001);
    repeat (8) begin
      d = $random(seed);
      e = d & 32'h0000_2FFC;
      wb(1, d[0] ? `OFF_FAST_SET : `OFF_NORMAL_SET, d);
      fen = d[0] ? fen | e : fen & ~e;
      nen = d[0] ? nen & ~e : nen | e;
      wb(1, d[0] ? `OFF_FAST_CLR : `OFF_NORMAL_CLR, d >> 8);
      if (d[0]) fen = fen & ~(d >> 8); else nen = nen & ~(d >> 8);
      raise <= 11'($random(seed));
      drop <= 11'($random(seed));
      d = $random(seed);
      pd <= d[3];
      cfg = d[2:0] & 3'b110;
      wb(1, `OFF_PROG_CFG, d);
      wb(1, `OFF_NORMAL_RAW, '1);
      hw = {18'b0, gpio, 1'b0, preq, 2'b0};
      rd(`OFF_PROG_CFG, {29'b0, cfg});
      for (int a = 0; a < 32; a += 4) rd(a[7:0], exp_reg(a[7:0]));
      @(negedge clock);
      chk({31'b0, nreq}, {31'b0, |exp_reg(`OFF_NORMAL_STA)});
      chk({31'b0, freq}, {31'b0, |(exp_reg(`OFF_FAST_STA) >> 1)});
      chk({31'b0, wake}, {31'b0, pd & |(hw & (nen | fen))});
    end
    $display("Random register test done");
    raise <= '0;
    drop <= '1;
    pd <= 0;
    wb(1, `OFF_PROG_CFG, '0);
    wb(1, `OFF_NORMAL_CLR, '1);
    wb(1, `OFF_EVT_STATUS, '1);
    rd(`OFF_EVT_STATUS, '0);
    wb(1, `OFF_NORMAL_SET, 32'h0000_0004);
    drop <= '0;
    raise <= 11'h001;
    repeat (3) @(posedge clock);
    rd(`OFF_EVT_STATUS, 32'h0000_0001);
    chk({31'b0, iout}, 32'h0000_0001);
    wb(1, `OFF_EVT_MASK, '0);
    @(negedge clock);
    @(negedge clock);
    chk({31'b0, iout}, '0);
    $display("Event test done");
    test_done();
  end
endmodule
`default_nettype wire
